// ### overcurrent_hiccup_fault_control.sv
`timescale 1ns/1ps
module overcurrent_hiccup_fault_control #(
    parameter int BLANK_LEN = scp_pkg::BLANK_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic cycle_start,
    input  wire logic pwm_request,
    input  wire logic overcurrent_raw,
    input  wire logic switch_node_high,
    input  wire logic soft_start_low,
    input  wire logic soft_start_done,
    input  wire logic supply_below_lo,
    input  wire logic supply_above_hi,
    output logic      high_side_gate_drive,
    output logic      low_side_gate_drive,
    output logic      current_limit_reference,
    output logic      pwm_enable,
    output logic      fault_active,
    output logic      regulator_mode,
    output logic [2:0] fault_count
);
    import scp_pkg::*;

    // ==================================================
    // Input synchronisers
    // ==================================================
    // Comparator and pin levels are asynchronous to the cycle clock.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] meta;
    logic [NSYNC-1:0] sync;
    assign sync_in = {cycle_start, pwm_request, overcurrent_raw,
                      switch_node_high, soft_start_low, soft_start_done,
                      supply_below_lo, supply_above_hi};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= sync_in;
            sync <= meta;
        end
    end
    logic cyc_lvl, pwm_s, oc_s, swh_s, ss_low_s, ss_done_lvl, vlo_s, vhi_s;
    assign {cyc_lvl, pwm_s, oc_s, swh_s, ss_low_s, ss_done_lvl,
            vlo_s, vhi_s} = sync;

    // ==================================================
    // Edge detection of cycle and soft-start events
    // ==================================================
    logic cyc_d;
    logic ssd_d;
    logic next_cyc_d;
    logic next_ssd_d;
    logic cyc_pulse;
    logic ss_done_pulse;
    always_comb begin
        next_cyc_d    = cyc_lvl;
        next_ssd_d    = ss_done_lvl;
        cyc_pulse     = cyc_lvl & ~cyc_d;
        ss_done_pulse = ss_done_lvl & ~ssd_d;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cyc_d <= 1'b0;
            ssd_d <= 1'b0;
        end else begin
            cyc_d <= next_cyc_d;
            ssd_d <= next_ssd_d;
        end
    end

    // ==================================================
    // Mode, counter, pulse and blanking state
    // ==================================================
    mode_t            mode;
    mode_t            next_mode;
    logic [2:0]       count;
    logic [2:0]       next_count;
    logic             hs_on;
    logic             next_hs_on;
    logic             oc_latched;
    logic             next_oc_latched;
    logic             blanking;
    logic             next_blanking;
    logic [BLANK_W-1:0] blank_cnt;
    logic [BLANK_W-1:0] next_blank_cnt;
    logic             first_pulse;
    logic             next_first_pulse;
    logic             ls_on;
    logic             next_ls_on;
    logic             oc_cycle;
    logic             next_oc_cycle;
    logic             reg_mode;
    logic             next_reg_mode;
    logic             oc_trip;

    // Sensing is only meaningful with the gate high and blanking over.
    assign oc_trip = hs_on & ~blanking & oc_s;

    always_comb begin
        next_mode        = mode;
        next_count       = count;
        next_hs_on       = hs_on;
        next_oc_latched  = oc_latched;
        next_blanking    = blanking;
        next_blank_cnt   = blank_cnt;
        next_first_pulse = first_pulse;
        next_ls_on       = ls_on;
        next_oc_cycle    = oc_cycle;

        if (vlo_s) begin
            next_reg_mode = 1'b0;
        end else if (vhi_s) begin
            next_reg_mode = 1'b1;
        end else begin
            next_reg_mode = reg_mode;
        end

        case (mode)
            ST_SHUTDOWN: begin
                next_hs_on    = 1'b0;
                next_ls_on    = 1'b0;
                next_blanking = 1'b0;
                if (!ss_low_s) begin
                    next_mode        = ST_SOFTSTART;
                    next_first_pulse = 1'b0;
                end
            end
            ST_SOFTSTART, ST_NORMAL: begin
                if (cyc_pulse) begin
                    // Close out the previous cycle in the counter.
                    if (oc_cycle) begin
                        if (count != FAULT_LIMIT) begin
                            next_count = count + FAULT_ONE;
                        end
                    end else if (count != FAULT_ZERO) begin
                        next_count = count - FAULT_ONE;
                    end
                    next_oc_cycle   = 1'b0;
                    next_oc_latched = 1'b0;
                    next_ls_on      = 1'b0;
                    if (pwm_s) begin
                        next_hs_on     = 1'b1;
                        next_blanking  = 1'b1;
                        next_blank_cnt = '0;
                    end
                end else begin
                    if (blanking) begin
                        if (swh_s) begin
                            next_blanking = 1'b0;
                        end else if (blank_cnt ==
                                     BLANK_W'(BLANK_LEN - 1)) begin
                            next_blanking = 1'b0;
                        end else begin
                            next_blank_cnt = blank_cnt + 1'b1;
                        end
                    end
                    if (oc_trip) begin
                        next_hs_on      = 1'b0;
                        next_oc_latched = 1'b1;
                        next_oc_cycle   = 1'b1;
                        next_blanking   = 1'b0;
                    end else if (hs_on && !pwm_s) begin
                        next_hs_on = 1'b0;
                    end
                    if (hs_on && !next_hs_on) begin
                        next_first_pulse = 1'b1;
                        // Rectifier waits for each pulse to end.
                        next_ls_on = 1'b1;
                    end
                end
                if (mode == ST_SOFTSTART && first_pulse && ss_done_pulse) begin
                    next_mode = ST_NORMAL;
                end
                if (cyc_pulse && oc_cycle
                    && count == FAULT_LIMIT - FAULT_ONE) begin
                    next_mode     = ST_HICCUP;
                    next_hs_on    = 1'b0;
                    next_ls_on    = 1'b0;
                    next_blanking = 1'b0;
                end
            end
            ST_HICCUP: begin
                next_hs_on    = 1'b0;
                next_ls_on    = 1'b0;
                next_blanking = 1'b0;
                if (ss_done_pulse && count != FAULT_ZERO) begin
                    next_count = count - FAULT_ONE;
                end
                if (count == FAULT_ZERO) begin
                    next_mode        = ST_SOFTSTART;
                    next_first_pulse = 1'b0;
                end
            end
            default: next_mode = ST_SHUTDOWN;
        endcase

        if (ss_low_s) begin
            next_mode     = ST_SHUTDOWN;
            next_hs_on    = 1'b0;
            next_ls_on    = 1'b0;
            next_blanking = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode        <= ST_SHUTDOWN;
            count       <= FAULT_ZERO;
            hs_on       <= 1'b0;
            oc_latched  <= 1'b0;
            blanking    <= 1'b0;
            blank_cnt   <= '0;
            first_pulse <= 1'b0;
            ls_on       <= 1'b0;
            oc_cycle    <= 1'b0;
            reg_mode    <= 1'b0;
        end else begin
            mode        <= next_mode;
            count       <= next_count;
            hs_on       <= next_hs_on;
            oc_latched  <= next_oc_latched;
            blanking    <= next_blanking;
            blank_cnt   <= next_blank_cnt;
            first_pulse <= next_first_pulse;
            ls_on       <= next_ls_on;
            oc_cycle    <= next_oc_cycle;
            reg_mode    <= next_reg_mode;
        end
    end

    // ==================================================
    // Outputs
    // ==================================================
    // Gate drives come straight from flops; the reference pull-down
    // is the blanking flag itself.
    assign high_side_gate_drive    = hs_on;
    assign low_side_gate_drive     = ls_on;
    assign current_limit_reference = blanking;
    assign pwm_enable              = (mode == ST_SOFTSTART)
                                     || (mode == ST_NORMAL);
    assign fault_active            = (mode == ST_HICCUP);
    assign regulator_mode          = reg_mode;
    assign fault_count             = count;

    // ==================================================
    // Checks
    // ==================================================
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence trip_s;
        hs_on && !blanking && oc_s;
    endsequence

    // A comparator level with the gate low or blanked must never count
    sense_gate_a: assert property (
        oc_s && (!hs_on || blanking) && !oc_cycle && !cyc_pulse
            |=> !oc_cycle) else $error("sensed while gate low");
    trip_ends_a: assert property (
        trip_s and !ss_low_s |=> !hs_on) else $error("pulse not ended");
    stay_off_a: assert property (
        oc_latched && !cyc_pulse |=> !hs_on)
        else $error("high side back on");
    ref_pull_a: assert property (
        $rose(hs_on) |-> blanking) else $error("no blanking at turn-on");
    node_rel_a: assert property (
        blanking && swh_s && !cyc_pulse |=> !blanking)
        else $error("blanking not released");
    blank_tmo_a: assert property (
        blanking && !cyc_pulse && blank_cnt == BLANK_W'(BLANK_LEN - 1)
            |=> !blanking) else $error("blanking timeout missed");
    hiccup_in_a: assert property (
        cyc_pulse && oc_cycle && count == FAULT_LIMIT - FAULT_ONE
            && (mode == ST_SOFTSTART || mode == ST_NORMAL) && !ss_low_s
            |=> fault_active) else $error("hiccup not entered");
    hiccup_idle_a: assert property (
        fault_active |-> !hs_on && !ls_on) else $error("drive in hiccup");
    drive_excl_a: assert property (
        hs_on |-> !ls_on) else $error("both drives on");
    count_sat_a: assert property (
        count == FAULT_LIMIT |=> count >= FAULT_LIMIT - FAULT_ONE)
        else $error("counter jumped");
    count_floor_a: assert property (
        count == FAULT_ZERO |=> count <= FAULT_ONE)
        else $error("counter wrapped below zero");
    shut_low_a: assert property (
        ss_low_s |=> !hs_on && !ls_on) else $error("drive in shutdown");
    reg_hold_a: assert property (
        !vlo_s && !vhi_s |=> reg_mode == $past(reg_mode))
        else $error("regulator mode moved");
    hiccup_exit_a: assert property (
        fault_active && count == FAULT_ZERO && !ss_low_s |=> !fault_active)
        else $error("hiccup not left");
endmodule // overcurrent_hiccup_fault_control

// ### scp_pkg.sv
package scp_pkg;
    // Fault counter limit and width
    localparam int         FAULT_CNT_W      = 3;
    localparam logic [2:0] FAULT_LIMIT      = 3'h7;
    localparam logic [2:0] FAULT_ZERO       = 3'h0;
    localparam logic [2:0] FAULT_ONE        = 3'h1;
    // Clock rate and blanking timeout
    localparam int         CLK_HZ           = 40_000_000;
    localparam int         BLANK_TIMEOUT_NS = 200;
    localparam int         BLANK_CYCLES     =
        (BLANK_TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int         BLANK_W          = 8;

    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_SOFTSTART,
        ST_NORMAL,
        ST_HICCUP
    } mode_t;
endpackage

// ### power_stage_model.sv
`timescale 1ns/1ps
// ==========================================================
// Power stage: switch node follows the high side, a short trips sense
module power_stage_model (
    input  wire logic ref_clk,
    input  wire logic hs,
    input  wire logic shorted,
    input  wire logic stuck,
    input  wire logic spurious,
    output logic      sw_high,
    output logic      oc
);
    initial begin
        sw_high = 1'b0;
        oc      = 1'b0;
    end
    // Stuck models a node that never climbs near the supply
    always @(posedge ref_clk) begin
        sw_high <= hs & ~stuck;
        oc      <= (hs & shorted) | spurious;
    end
endmodule // power_stage_model

// ### overcurrent_hiccup_fault_control_tb_top.sv
`timescale 1ns/1ps
module overcurrent_hiccup_fault_control_tb_top;
    import scp_pkg::*;
    localparam int BL = 10;
    logic ref_clk = 1'b0, rst = 1'b1, cycle_start = 1'b0, pwm_request = 1'b0;
    logic soft_start_low = 1'b1, soft_start_done = 1'b0;
    logic supply_below_lo = 1'b1, supply_above_hi = 1'b0;
    logic shorted = 1'b0, stuck = 1'b0, spurious = 1'b0;
    logic oc, sw_high, hs, ls, ref_pull, pwm_en, fault, reg_mode;
    logic [2:0] fault_count;
    int     fails = 0, compares = 0, ticks = 0, r;
    int     m_cnt = 0, m_oc = 0, m_reg = 0, m_hic = 0;
    integer seed = 75262;
    // ==========================================================
    // Design and power stage
    overcurrent_hiccup_fault_control #(.BLANK_LEN(BL)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .cycle_start(cycle_start),
        .pwm_request(pwm_request), .overcurrent_raw(oc),
        .switch_node_high(sw_high), .soft_start_low(soft_start_low),
        .soft_start_done(soft_start_done), .supply_below_lo(supply_below_lo),
        .supply_above_hi(supply_above_hi), .high_side_gate_drive(hs),
        .low_side_gate_drive(ls), .current_limit_reference(ref_pull),
        .pwm_enable(pwm_en), .fault_active(fault),
        .regulator_mode(reg_mode), .fault_count(fault_count));
    power_stage_model u_stage (.ref_clk(ref_clk), .hs(hs), .shorted(shorted),
        .stuck(stuck), .spurious(spurious), .sw_high(sw_high), .oc(oc));
    // ==========================================================
    // Clock, watchdog, report
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        ticks++;
        if (ticks == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [3:0] e,
                       input logic [3:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", what, e, g);
        end
    endtask
    // ==========================================================
    // One switching cycle, checked against the reference model
    task automatic run_cycle(input logic pulse);
        int hs_n, ref_n, ls_n, fell, rise2, ls_end, on;
        hs_n = 0; ref_n = 0; ls_n = 0; fell = 0; rise2 = 0; ls_end = 0;
        // The previous cycle's result is counted at this cycle edge
        if (!soft_start_low && !m_hic)
            m_cnt = m_oc ? m_cnt + 1 : (m_cnt > 0 ? m_cnt - 1 : 0);
        if (m_cnt == 7)
            m_hic = 1;
        on = pulse && !soft_start_low && !m_hic;
        @(negedge ref_clk);
        cycle_start = 1'b1;
        pwm_request = pulse;
        for (int i = 0; i < 24; i++) begin
            @(negedge ref_clk);
            if (hs === 1'b1 && hs_n == 0)
                chk("blank_at_on", 1, ref_pull);
            if (hs === 1'b1)
                chk("ls_with_hs", 0, ls);
            if (hs === 1'b1 && fell)
                rise2 = 1;
            if (hs !== 1'b1 && hs_n > 0)
                fell = 1;
            hs_n += (hs === 1'b1);
            ref_n += (ref_pull === 1'b1);
            ls_n += (i > 5 && ls !== 1'b0);
            ls_end = (ls === 1'b1);
        end
        cycle_start = 1'b0;
        pwm_request = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("hs_on", on, hs_n > 0);
        if (on) begin
            chk("trip", shorted, fell);
            chk("no_reon", 0, rise2);
            chk("ls_after", fell, ls_end);
            if (stuck)
                chk("blank_tmo", 1, ref_n >= BL && ref_n <= BL + 4);
            else
                chk("blank_sw", 1, ref_n > 0 && ref_n <= 7);
        end else if (m_hic || soft_start_low) begin
            chk("ls_idle", 0, ls_n > 0);
        end
        m_oc = on && shorted;
        chk("fault_count", m_cnt, fault_count);
        chk("fault_active", m_hic, fault);
        chk("pwm_enable", !m_hic && !soft_start_low, pwm_en);
    endtask
    // One soft-start period; counts down while in hiccup
    task automatic ss_step();
        int act;
        act = 0;
        @(negedge ref_clk);
        soft_start_done = 1'b1;
        repeat (6) @(negedge ref_clk);
        soft_start_done = 1'b0;
        repeat (6) begin
            @(negedge ref_clk);
            act += (hs !== 1'b0 || ls !== 1'b0);
        end
        if (m_hic) begin
            m_cnt--;
            chk("gate_idle", 0, act > 0);
            chk("hic_count", m_cnt, fault_count);
            m_hic = (m_cnt != 0);
            m_oc = 0;
            chk("restart", !m_hic, pwm_en);
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        chk("rst_hs", 0, hs);
        chk("rst_count", 0, fault_count);
        repeat (30) begin
            r = {$random(seed)} % 3;
            supply_below_lo = (r == 0);
            supply_above_hi = (r == 2);
            m_reg = (r == 0) ? 0 : (r == 2) ? 1 : m_reg;
            repeat (4) @(negedge ref_clk);
            chk("regulator_mode", m_reg, reg_mode);
        end
        run_cycle(1'b1);
        soft_start_low = 1'b0;
        repeat (4) @(negedge ref_clk);
        run_cycle(1'b1);
        ss_step();
        stuck = 1'b1;
        run_cycle(1'b1);
        stuck = 1'b0;
        spurious = 1'b1;
        run_cycle(1'b0);
        spurious = 1'b0;
        shorted = 1'b1;
        repeat (3) run_cycle(1'b1);
        shorted = 1'b0;
        repeat (4) run_cycle(1'b1);
        shorted = 1'b1;
        repeat (8) run_cycle(1'b1);
        repeat (7) ss_step();
        repeat (8) run_cycle(1'b1);
        shorted = 1'b0;
        repeat (7) ss_step();
        run_cycle(1'b1);
        soft_start_low = 1'b1;
        repeat (4) @(negedge ref_clk);
        run_cycle(1'b1);
        end_sim();
    end
endmodule // overcurrent_hiccup_fault_control_tb_top
